// >>> hw/acc_converter_control.sv
// Analog mode register, sample timers, A/D sequencing and D/A feed
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"
module acc_converter_control
  import acc_pkg::*;
#(
  parameter int ADC_DIV_8K  = `ACC_DIV(`ACC_HZ_8K),
  parameter int ADC_DIV_16K = `ACC_DIV(`ACC_HZ_16K),
  parameter int DAC_DIV_16K = `ACC_DIV(`ACC_HZ_16K),
  parameter int DAC_DIV_10K = `ACC_DIV(`ACC_HZ_10K),
  parameter int DAC_DIV_4K  = `ACC_DIV(`ACC_HZ_4K),
  parameter int BUF_DEPTH   = 2
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  ext_addr,
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  input  wire logic [15:0] ext_wdata,
  output logic [15:0]      ext_rdata,
  input  wire logic        adc_irq_clear,
  input  wire logic        dac_irq_clear,
  input  wire logic        external_interrupt_pin,
  input  wire logic [7:0]  adc_sample_data,
  output logic             adc_enable_out,
  output logic             adc_convert_out,
  output logic             general_output_pin_a,
  output logic             general_output_pin_b,
  output logic             adc_irq_flag,
  output logic             dac_irq_flag,
  output logic             int_zero_req,
  output logic             dac_wr_ready,
  output logic             pwm_out
);
  localparam int CONV_CYC = `ACC_CONV_CYC;
  localparam int PTR_W    = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W    = $clog2(BUF_DEPTH + 1);

  if (BUF_DEPTH < 1 || DAC_DIV_4K > 65535 || ADC_DIV_8K > 65535 || CONV_CYC > 511) begin : g_chk
    $error("acc_converter_control: parameter out of range");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] mode_reg, mode_next;
  logic        done_reg, done_next;
  logic [7:0]  result_reg, result_next;
  logic [2:0]  adc_rate_act_reg, adc_rate_act_next;
  logic [15:0] adc_cnt_reg, adc_cnt_next;
  logic [15:0] dac_cnt_reg, dac_cnt_next;
  logic [8:0]  conv_cnt_reg, conv_cnt_next;
  acc_state_t  state_reg, state_next;
  logic        adc_irq_reg, adc_irq_next;
  logic        dac_irq_reg, dac_irq_next;
  logic        int0_reg, int0_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [9:0]  buf_mem [BUF_DEPTH];
  logic [9:0]  buf_wdata;
  logic [PTR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic        rdy_reg, rdy_next;
  logic [9:0]  pwm_val_reg, pwm_val_next;
  logic        pwm_start_reg, pwm_start_next;
  logic [15:0] act_reg, act_next;

  logic        wr_mode, wr_data, rd_data, push, pop;
  logic        adc_tick, dac_tick, launch, conv_end, done_set;
  logic [15:0] adc_lim, dac_lim;

  // ------------------------------------------------------------
  // Decode and timer limits
  // ------------------------------------------------------------
  always_comb begin
    wr_mode = 1'b0;
    wr_data = 1'b0;
    rd_data = 1'b0;
    if (ext_addr == `ACC_ADDR_MODE) begin
      wr_mode = ext_wr;
    end else if (ext_addr == `ACC_ADDR_DATA) begin
      wr_data = ext_wr;
      rd_data = ext_rd;
    end
    // A/D period from the copy taken at the last start
    case (adc_rate_act_reg)
      `ACC_ADC_128K: adc_lim = 16'(`ACC_DIV(`ACC_HZ_128K));
      `ACC_ADC_64K:  adc_lim = 16'(`ACC_DIV(`ACC_HZ_64K));
      `ACC_ADC_32K:  adc_lim = 16'(`ACC_DIV(`ACC_HZ_32K));
      `ACC_ADC_16K:  adc_lim = 16'(ADC_DIV_16K);
      `ACC_ADC_8K:   adc_lim = 16'(ADC_DIV_8K);
      default:       adc_lim = 16'h0000;
    endcase
    // D/A period; reserved codes stop the timer
    case (mode_reg[`ACC_B_DAC_RATE+:3])
      `ACC_DAC_64K: dac_lim = 16'(`ACC_DIV(`ACC_HZ_64K));
      `ACC_DAC_16K: dac_lim = 16'(DAC_DIV_16K);
      `ACC_DAC_10K: dac_lim = 16'(DAC_DIV_10K);
      `ACC_DAC_4K:  dac_lim = 16'(DAC_DIV_4K);
      default:      dac_lim = 16'h0000;
    endcase
    adc_tick = (adc_lim != 16'h0000) && (adc_cnt_reg == 16'(adc_lim - 16'h0001));
    dac_tick = (dac_lim != 16'h0000) && (dac_cnt_reg == 16'(dac_lim - 16'h0001));
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    // Writable bits only; done and reserved bits ignore writes
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = ext_wdata & `ACC_MODE_WMASK;
    end
    // Write of a one, or a timer time-out while the start bit is clear, launches while enabled
    launch = mode_next[`ACC_B_ADC_EN] &&
             ((wr_mode && ext_wdata[`ACC_B_START]) || (adc_tick && !mode_reg[`ACC_B_START]));
    adc_cnt_next = adc_tick ? 16'h0000 : 16'(adc_cnt_reg + 16'h0001);
    if (adc_lim == 16'h0000) begin
      adc_cnt_next = 16'h0000;
    end
    dac_cnt_next = dac_tick ? 16'h0000 : 16'(dac_cnt_reg + 16'h0001);
    if (dac_lim == 16'h0000) begin
      dac_cnt_next = 16'h0000;
    end
    adc_rate_act_next = launch ? mode_next[`ACC_B_ADC_RATE+:3] : adc_rate_act_reg;

    // Conversion sequencer; a start mid-conversion restarts it
    state_next    = state_reg;
    conv_cnt_next = conv_cnt_reg;
    result_next   = result_reg;
    conv_end      = 1'b0;
    case (state_reg)
      ACC_IDLE: begin
        if (launch) begin
          state_next    = ACC_CONV;
          conv_cnt_next = 9'h000;
        end
      end
      ACC_CONV: begin
        if (launch) begin
          conv_cnt_next = 9'h000;
        end else if (!mode_next[`ACC_B_ADC_EN]) begin
          state_next = ACC_IDLE;
        end else if (conv_cnt_reg == 9'(CONV_CYC - 1)) begin
          state_next  = ACC_IDLE;
          result_next = adc_sample_data;
          conv_end    = 1'b1;
        end else begin
          conv_cnt_next = 9'(conv_cnt_reg + 9'h001);
        end
      end
      default: begin
        state_next = ACC_IDLE;
      end
    endcase

    // Flags: a set in the cycle of a clear wins
    done_set     = conv_end;
    done_next    = done_set || (done_reg && !(rd_data));
    adc_irq_next = conv_end || (adc_irq_reg && !adc_irq_clear);
    dac_irq_next = dac_tick || (dac_irq_reg && !dac_irq_clear);
    int0_next    = mode_reg[`ACC_B_INT0SEL] ? external_interrupt_pin : dac_irq_reg;

    // Read data, registered
    rdata_next = rdata_reg;
    if (ext_rd) begin
      if (ext_addr == `ACC_ADDR_MODE) begin
        rdata_next = mode_reg;
        rdata_next[`ACC_B_DONE] = done_reg;
      end else if (ext_addr == `ACC_ADDR_DATA) begin
        rdata_next = {6'h00, result_reg, 2'b00};
      end else begin
        rdata_next = 16'h0000;
      end
    end

    // Two-entry sample buffer drained at each D/A period
    push      = wr_data && (cnt_reg != CNT_W'(BUF_DEPTH));
    pop       = dac_tick && (cnt_reg != '0);
    buf_wdata = ext_wdata[9:0];
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (push) begin
      wptr_next = (wptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : PTR_W'(wptr_reg + 1'b1);
    end
    if (pop) begin
      rptr_next = (rptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : PTR_W'(rptr_reg + 1'b1);
    end
    cnt_next = CNT_W'(cnt_reg + CNT_W'(push) - CNT_W'(pop));
    rdy_next = cnt_next != CNT_W'(BUF_DEPTH);
    pwm_val_next = pwm_val_reg;
    if (pop) begin
      pwm_val_next = buf_mem[rptr_reg];
    end
    // 8-bit resolution at the fastest rate
    if (mode_reg[`ACC_B_DAC_RATE+:3] == `ACC_DAC_64K) begin
      pwm_val_next = pwm_val_next & `ACC_RES8_MASK;
    end
    pwm_start_next = dac_tick;
    // Active region 4/5 of the period, whole period at 10 kHz
    if (mode_reg[`ACC_B_DAC_RATE+:3] == `ACC_DAC_10K) begin
      act_next = dac_lim;
    end else begin
      act_next = 16'((32'(dac_lim) * 32'(`ACC_ACT_NUM)) / 32'(`ACC_ACT_DEN));
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg         <= `ACC_MODE_RST;
      done_reg         <= 1'b0;
      result_reg       <= 8'h00;
      adc_rate_act_reg <= 3'h0;
      adc_cnt_reg      <= 16'h0000;
      dac_cnt_reg      <= 16'h0000;
      conv_cnt_reg     <= 9'h000;
      state_reg        <= ACC_IDLE;
      adc_irq_reg      <= 1'b0;
      dac_irq_reg      <= 1'b0;
      int0_reg         <= 1'b0;
      rdata_reg        <= 16'h0000;
      wptr_reg         <= '0;
      rptr_reg         <= '0;
      cnt_reg          <= '0;
      rdy_reg          <= 1'b1;
      pwm_val_reg      <= 10'h000;
      pwm_start_reg    <= 1'b0;
      act_reg          <= 16'h0000;
    end else begin
      mode_reg         <= mode_next;
      done_reg         <= done_next;
      result_reg       <= result_next;
      adc_rate_act_reg <= adc_rate_act_next;
      adc_cnt_reg      <= adc_cnt_next;
      dac_cnt_reg      <= dac_cnt_next;
      conv_cnt_reg     <= conv_cnt_next;
      state_reg        <= state_next;
      adc_irq_reg      <= adc_irq_next;
      dac_irq_reg      <= dac_irq_next;
      int0_reg         <= int0_next;
      rdata_reg        <= rdata_next;
      wptr_reg         <= wptr_next;
      rptr_reg         <= rptr_next;
      cnt_reg          <= cnt_next;
      rdy_reg          <= rdy_next;
      pwm_val_reg      <= pwm_val_next;
      pwm_start_reg    <= pwm_start_next;
      act_reg          <= act_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wptr_reg] <= buf_wdata;
    end
  end

  acc_pwm_slicer u_pwm (
    .clk           (clk),
    .rst           (rst),
    .period_start  (pwm_start_reg),
    .active_cycles (act_reg),
    .value         (pwm_val_reg),
    .pwm_out       (pwm_out)
  );

  assign ext_rdata            = rdata_reg;
  assign adc_enable_out       = mode_reg[`ACC_B_ADC_EN];
  assign adc_convert_out      = state_reg[1];
  assign general_output_pin_a = mode_reg[`ACC_B_PIN_A];
  assign general_output_pin_b = mode_reg[`ACC_B_PIN_B];
  assign adc_irq_flag         = adc_irq_reg;
  assign dac_irq_flag         = dac_irq_reg;
  assign int_zero_req         = int0_reg;
  assign dac_wr_ready         = rdy_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
    ext_rd && ext_addr == `ACC_ADDR_MODE |=> ext_rdata[14:11] == 4'h0)
    else $error("reserved mode bits read nonzero");
  AST_DONE_CLEAR: assert property (@(posedge clk) disable iff (rst)
    done_reg && rd_data && !conv_end |=> !done_reg)
    else $error("done flag not cleared by data read");
  AST_CONV_BOUND: assert property (@(posedge clk) disable iff (rst)
    $rose(adc_convert_out) |-> ##[1:250] (!adc_convert_out || conv_cnt_reg == 9'h000))
    else $error("conversion overran its time");
  AST_DISABLED: assert property (@(posedge clk) disable iff (rst)
    !adc_enable_out && !(wr_mode && ext_wdata[5]) |=> !adc_convert_out && !$rose(done_reg))
    else $error("conversion while disabled");
  AST_START: assert property (@(posedge clk) disable iff (rst)
    wr_mode && ext_wdata[3] && ext_wdata[5] |=> adc_convert_out && conv_cnt_reg == 9'h000)
    else $error("start write did not launch");
  AST_END_FLAGS: assert property (@(posedge clk) disable iff (rst)
    conv_end |=> adc_irq_flag && done_reg &&
                 (ext_rdata == $past(ext_rdata) || $past(ext_rd)))
    else $error("conversion end did not set flags");
  AST_PIN: assert property (@(posedge clk) disable iff (rst)
    wr_mode |=> general_output_pin_a == $past(ext_wdata[6]) &&
                general_output_pin_b == $past(ext_wdata[7]))
    else $error("output pins do not follow mode write");
  AST_DAC_IRQ: assert property (@(posedge clk) disable iff (rst)
    dac_tick |=> dac_irq_flag ##1 (u_pwm.slot_reg == 11'h000))
    else $error("dac tick did not set flag or restart pwm");
  AST_INT0: assert property (@(posedge clk) disable iff (rst)
    mode_reg[15] && !wr_mode |=> int_zero_req == $past(external_interrupt_pin))
    else $error("interrupt zero source wrong");
  AST_FULL: assert property (@(posedge clk) disable iff (rst)
    cnt_reg == CNT_W'(BUF_DEPTH) |-> !dac_wr_ready)
    else $error("ready high with full buffer");
endmodule
`default_nettype wire

// >>> hw/acc_defs.svh
// Constants for the analog converter control block
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define ACC_CLK_HZ        125000000
`define ACC_DIV(hz)       (`ACC_CLK_HZ / (hz))
`define ACC_CONV_NS       2000
`define ACC_CONV_CYC      ((`ACC_CONV_NS * (`ACC_CLK_HZ / 1000000)) / 1000)
`define ACC_ACT_NUM       4
`define ACC_ACT_DEN       5
`define ACC_PWM_SLOTS     1024

// ------------------------------------------------------------
// Register port addresses
// ------------------------------------------------------------
`define ACC_ADDR_DATA     3'h5
`define ACC_ADDR_MODE     3'h6

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define ACC_B_INT0SEL     15
`define ACC_B_DAC_RATE    8
`define ACC_B_PIN_B       7
`define ACC_B_PIN_A       6
`define ACC_B_ADC_EN      5
`define ACC_B_DONE        4
`define ACC_B_START       3
`define ACC_B_ADC_RATE    0
`define ACC_MODE_RST      16'h0008
`define ACC_MODE_WMASK    16'h87EF
`define ACC_RES8_MASK     10'h3FC

// ------------------------------------------------------------
// Rate codes and rates
// ------------------------------------------------------------
`define ACC_DAC_64K       3'h4
`define ACC_DAC_16K       3'h2
`define ACC_DAC_10K       3'h3
`define ACC_DAC_4K        3'h1
`define ACC_ADC_128K      3'h4
`define ACC_ADC_64K       3'h2
`define ACC_ADC_32K       3'h3
`define ACC_ADC_16K       3'h1
`define ACC_ADC_8K        3'h0
`define ACC_HZ_128K       128000
`define ACC_HZ_64K        64000
`define ACC_HZ_32K        32000
`define ACC_HZ_16K        16000
`define ACC_HZ_10K        10000
`define ACC_HZ_8K         8000
`define ACC_HZ_4K         4000

`endif

// >>> hw/acc_pkg.sv
// Types for the analog converter control block
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_t;
endpackage

// >>> hw/acc_pwm_slicer.sv
// Sliced PWM generator for the D/A path
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"
module acc_pwm_slicer
  import acc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        period_start,
  input  wire logic [15:0] active_cycles,
  input  wire logic [9:0]  value,
  output logic             pwm_out
);
  // ------------------------------------------------------------
  // Slot stepping
  // ------------------------------------------------------------
  logic [15:0] act_reg, act_next;
  logic [9:0]  val_reg, val_next;
  logic [15:0] acc_reg, acc_next;
  logic [10:0] slot_reg, slot_next;
  logic        pwm_reg, pwm_next;
  logic [16:0] acc_sum;
  logic        slot_bit;

  always_comb begin
    act_next  = act_reg;
    val_next  = val_reg;
    acc_next  = acc_reg;
    slot_next = slot_reg;
    acc_sum   = 17'({1'b0, acc_reg} + 17'(`ACC_PWM_SLOTS));
    if (period_start) begin
      act_next  = active_cycles;
      val_next  = value;
      acc_next  = 16'h0000;
      slot_next = 11'h000;
    end else if (slot_reg < 11'(`ACC_PWM_SLOTS)) begin
      // Fractional stepping spreads 1024 slots over the active region
      if (acc_sum >= {1'b0, act_reg}) begin
        acc_next  = 16'(acc_sum - {1'b0, act_reg});
        slot_next = 11'(slot_reg + 11'h001);
      end else begin
        acc_next  = acc_sum[15:0];
      end
    end
    // Fine slot first, coarse slots follow; fine in lowest groups
    if (slot_reg[4:0] == 5'h00) begin
      slot_bit = slot_reg[9:5] < val_reg[4:0];
    end else begin
      slot_bit = (slot_reg[4:0] - 5'h01) < val_reg[9:5];
    end
    // Low outside the active region
    pwm_next = (slot_reg < 11'(`ACC_PWM_SLOTS)) && slot_bit && !period_start;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_reg  <= 16'hFFFF;
      val_reg  <= 10'h000;
      acc_reg  <= 16'h0000;
      slot_reg <= 11'(`ACC_PWM_SLOTS);
      pwm_reg  <= 1'b0;
    end else begin
      act_reg  <= act_next;
      val_reg  <= val_next;
      acc_reg  <= acc_next;
      slot_reg <= slot_next;
      pwm_reg  <= pwm_next;
    end
  end

  assign pwm_out = pwm_reg;
endmodule
`default_nettype wire

// >>> testbench/acc_converter_control_tb_top.sv
// Testbench for the analog converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_converter_control_tb_top;
  logic        clk, rst, adc_irq_clear, dac_irq_clear, ext_pin;
  logic        ext_wr, ext_rd, adc_enable_out, adc_convert_out, pin_a, pin_b;
  logic        adc_irq_flag, dac_irq_flag, int_zero_req, dac_wr_ready, pwm_out;
  logic [2:0]  ext_addr;
  logic [7:0]  adc_sample_data;
  logic [15:0] ext_wdata, ext_rdata, v;
  int          fails, check_count, cyc, n, hi, tail;

  acc_converter_control #(.ADC_DIV_8K(600), .ADC_DIV_16K(300), .DAC_DIV_16K(1280),
    .DAC_DIV_10K(1280), .DAC_DIV_4K(1280)) dut (
    .clk(clk), .rst(rst), .ext_addr(ext_addr), .ext_wr(ext_wr), .ext_rd(ext_rd),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .adc_irq_clear(adc_irq_clear),
    .dac_irq_clear(dac_irq_clear), .external_interrupt_pin(ext_pin),
    .adc_sample_data(adc_sample_data), .adc_enable_out(adc_enable_out),
    .adc_convert_out(adc_convert_out), .general_output_pin_a(pin_a),
    .general_output_pin_b(pin_b), .adc_irq_flag(adc_irq_flag),
    .dac_irq_flag(dac_irq_flag), .int_zero_req(int_zero_req),
    .dac_wr_ready(dac_wr_ready), .pwm_out(pwm_out));

  acc_dsp_model dsp (.clk(clk), .ext_addr(ext_addr), .ext_wr(ext_wr), .ext_rd(ext_rd),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  // ----------------------------------------------------------
  // Comparison, verdict and timeout
  // ----------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      complete_run;
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    dsp.rd(3'h6, v);
    chk(v, 16'h0008);
    chk(adc_convert_out, 16'h0000);
    chk(dac_wr_ready, 16'h0001);
  endtask

  task automatic t_mode;
    dsp.wr(3'h6, 16'hFFFF);
    dsp.rd(3'h6, v);
    chk(v, 16'h87EF);
    chk({pin_b, pin_a}, 16'h0003);
    chk(adc_enable_out, 16'h0001);
    dsp.wr(3'h6, 16'h0000);
    chk({pin_b, pin_a, adc_enable_out}, 16'h0000);
  endtask

  task automatic conv_len(output int len);
    len = 0;
    while (adc_convert_out === 1'b1 && len < 400) begin
      @(negedge clk);
      len++;
    end
  endtask

  task automatic t_conv;
    adc_sample_data = 8'hA5;
    dsp.wr(3'h6, 16'h0028);
    conv_len(n);
    chk(n, 16'd250);
    chk(adc_irq_flag, 16'h0001);
    dsp.rd(3'h6, v);
    chk(v, 16'h0038);
    dsp.rd(3'h5, v);
    chk(v, 16'h0294);
    dsp.rd(3'h6, v);
    chk(v, 16'h0028);
    chk(adc_irq_flag, 16'h0001);
    adc_irq_clear = 1'b1;
    @(negedge clk);
    adc_irq_clear = 1'b0;
    @(negedge clk);
    chk(adc_irq_flag, 16'h0000);
  endtask

  task automatic t_restart;
    dsp.wr(3'h6, 16'h002C);
    repeat (100) @(negedge clk);
    dsp.wr(3'h6, 16'h0028);
    conv_len(n);
    chk(n, 16'd250);
  endtask

  task automatic t_disabled;
    dsp.rd(3'h5, v);
    dsp.wr(3'h6, 16'h0008);
    repeat (300) @(negedge clk);
    chk(adc_convert_out, 16'h0000);
    dsp.rd(3'h6, v);
    chk(v, 16'h0008);
  endtask

  task automatic next_launch(output int len);
    len = 0;
    while (adc_convert_out !== 1'b0 && len < 2000) begin
      @(negedge clk);
      len++;
    end
    while (adc_convert_out !== 1'b1 && len < 2000) begin
      @(negedge clk);
      len++;
    end
  endtask

  task automatic t_timer;
    logic [2:0] codes [2] = '{3'h1, 3'h0};
    int         exp [2] = '{300, 600};
    for (int i = 0; i < 2; i++) begin
      dsp.wr(3'h6, {13'h0004, codes[i]});
      repeat (3) next_launch(n);
      chk(n, exp[i]);
    end
    dsp.wr(3'h6, 16'h0000);
  endtask

  task automatic dac_period(output int len, output int high, output int late);
    len = 0;
    high = pwm_out;
    late = 0;
    dac_irq_clear = 1'b1;
    @(negedge clk);
    dac_irq_clear = 1'b0;
    while (dac_irq_flag !== 1'b1 && len < 2000) begin
      high += pwm_out;
      late += (len >= 1030) ? pwm_out : 0;
      len++;
      @(negedge clk);
    end
  endtask

  task automatic t_dac;
    dsp.wr(3'h5, 16'hFD3A);
    dsp.wr(3'h5, 16'h03FF);
    chk(dac_wr_ready, 16'h0000);
    dsp.wr(3'h5, 16'h0000);
    dsp.wr(3'h6, 16'h0200);
    n = 0;
    while (dac_irq_flag !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk(int_zero_req, 16'h0001);
    dac_period(n, hi, tail);
    chk(n, 16'd1278);
    chk(hi, 16'd314);
    chk(tail, 16'd0);
    chk(dac_wr_ready, 16'h0001);
    dac_period(n, hi, tail);
    chk(n, 16'd1279);
    chk(hi, 16'd1023);
    dsp.wr(3'h6, 16'h8000);
    @(negedge clk);
    chk(int_zero_req, 16'h0000);
    ext_pin = 1'b1;
    repeat (3) @(negedge clk);
    chk(int_zero_req, 16'h0001);
  endtask

  initial begin
    rst = 1'b1;
    adc_irq_clear = 1'b0;
    dac_irq_clear = 1'b0;
    ext_pin = 1'b0;
    adc_sample_data = 8'h00;
    fails = 0;
    check_count = 0;
    cyc = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_mode();
    t_conv();
    t_restart();
    t_disabled();
    t_timer();
    t_dac();
    complete_run;
  end
endmodule
`default_nettype wire

// >>> testbench/acc_dsp_model.sv
// DSP core model driving the external register port
`timescale 1ns/1ps
`default_nettype none
module acc_dsp_model (
  input  wire logic        clk,
  output logic [2:0]       ext_addr,
  output logic             ext_wr,
  output logic             ext_rd,
  output logic [15:0]      ext_wdata,
  input  wire logic [15:0] ext_rdata
);
  initial begin
    ext_addr = 3'h0;
    ext_wr = 1'b0;
    ext_rd = 1'b0;
    ext_wdata = 16'h0000;
  end

  // One-cycle write; start commands go only through here
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    ext_addr = a;
    ext_wdata = d;
    ext_wr = 1'b1;
    @(negedge clk);
    ext_wr = 1'b0;
    ext_wdata = ~d;
  endtask

  // One-cycle read, data taken the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge clk);
    ext_addr = a;
    ext_rd = 1'b1;
    @(negedge clk);
    ext_rd = 1'b0;
    d = ext_rdata;
  endtask
endmodule
`default_nettype wire
